// ===== srl_pkg.sv
// Constants shared by the set-reset latch block: register map, field positions,
// reset values and pulse generator sizing.
// Assumes a 32-bit APB register bus and one system clock.
package srl_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] SRL_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] SRL_ADDR_SRC    = 8'h04;
   localparam logic [7:0] SRL_ADDR_STATUS = 8'h08;
   localparam int         SRL_ADDR_W      = 8;
   localparam int         SRL_REG_W       = 8;

   // ==========================================================
   // Control register fields
   localparam int SRL_CTRL_LEN  = 7;
   localparam int SRL_CTRL_DIVH = 6;
   localparam int SRL_CTRL_DIVL = 4;
   localparam int SRL_CTRL_QEN  = 3;
   localparam int SRL_CTRL_NQEN = 2;
   localparam int SRL_CTRL_PSET = 1;
   localparam int SRL_CTRL_PRST = 0;

   // ==========================================================
   // Source select fields
   localparam int SRL_SRC_PIN_SET  = 7;
   localparam int SRL_SRC_CLK_SET  = 6;
   localparam int SRL_SRC_C2_SET   = 5;
   localparam int SRL_SRC_C1_SET   = 4;
   localparam int SRL_SRC_PIN_RST  = 3;
   localparam int SRL_SRC_CLK_RST  = 2;
   localparam int SRL_SRC_C2_RST   = 1;
   localparam int SRL_SRC_C1_RST   = 0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] SRL_CTRL_RST = 8'h00;
   localparam logic [7:0] SRL_SRC_RST  = 8'h00;

   // ==========================================================
   // Pulse generator: shortest period 4, longest 512 cycles
   localparam int         SRL_DIV_CNT_W = 9;
   localparam logic [8:0] SRL_DIV_BASE  = 9'h004;

   // ==========================================================
   // Bus state
   typedef enum logic [1:0] {
      SRL_BUS_IDLE   = 2'b00,
      SRL_BUS_ACCESS = 2'b01
   } srl_bus_t;
endpackage : srl_pkg

// ===== srl_latch.sv
// Set-reset latch peripheral with APB register access.
// Assumes pin and comparator inputs are synchronous to core_clk.
`timescale 1ns/1ps
module srl_latch
#(
   parameter bit HAS_COMP_TWO = 1'b1
) (
   input  wire logic                            core_clk,
   input  wire logic                            rst_b,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [srl_pkg::SRL_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                     pwdata,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire logic                            latch_input_pin,
   input  wire logic                            first_comparator,
   input  wire logic                            second_comparator,
   output logic                                 true_output_pin,
   output logic                                 true_output_drive,
   output logic                                 inverted_output_pin,
   output logic                                 inverted_output_drive
);
   import srl_pkg::*;

   // ==========================================================
   // Elaboration check
   if (SRL_DIV_CNT_W != 9) begin : g_bad_width
      $error("srl_latch: divider counter must be 9 bits");
   end

   // ==========================================================
   // Helpers
   function automatic logic [8:0] period_mask(input logic [2:0] sel);
      logic [8:0] p;
      p = SRL_DIV_BASE << sel;
      return p - 9'h001;
   endfunction : period_mask

   function automatic logic is_mapped(input logic [SRL_ADDR_W-1:0] a);
      return (a == SRL_ADDR_CTRL) || (a == SRL_ADDR_SRC) || (a == SRL_ADDR_STATUS);
   endfunction : is_mapped

   // ==========================================================
   // Registers and state
   logic [SRL_REG_W-1:0] latch_control;
   logic [SRL_REG_W-1:0] latch_source_select;
   logic                 software_set_pulse;
   logic                 software_reset_pulse;
   logic [8:0]           div_cnt;
   logic                 div_pulse;
   logic                 latch_q;
   logic                 set_in;
   logic                 rst_in;
   logic                 bus_setup;
   logic                 bus_write;
   logic                 ctrl_wr;
   logic                 src_wr;
   srl_bus_t             bus_state;
   logic [2:0]           pulse_divider_select;
   logic                 latch_enable_bit;
   logic                 true_output_enable;
   logic                 inverted_output_enable;
   logic                 comp_two;

   assign pulse_divider_select   = latch_control[SRL_CTRL_DIVH:SRL_CTRL_DIVL];
   assign latch_enable_bit       = latch_control[SRL_CTRL_LEN];
   assign true_output_enable     = latch_control[SRL_CTRL_QEN];
   assign inverted_output_enable = latch_control[SRL_CTRL_NQEN];
   assign comp_two               = HAS_COMP_TWO & second_comparator;

   // ==========================================================
   // APB slave
   // Answer comes from flops, so data is fetched in the setup cycle
   // and pready rises in the first access cycle: no wait states.
   assign bus_setup = psel && !penable;
   assign bus_write = psel && penable && pready && pwrite;
   assign ctrl_wr   = bus_write && (paddr == SRL_ADDR_CTRL);
   assign src_wr    = bus_write && (paddr == SRL_ADDR_SRC);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_state <= SRL_BUS_IDLE;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
      end else begin
         case (bus_state)
            SRL_BUS_IDLE: begin
               if (bus_setup) begin
                  bus_state <= SRL_BUS_ACCESS;
                  pready    <= 1'b1;
                  pslverr   <= !is_mapped(paddr);
               end
            end
            SRL_BUS_ACCESS: begin
               bus_state <= SRL_BUS_IDLE;
               pready    <= 1'b0;
               pslverr   <= 1'b0;
            end
            default: begin
               bus_state <= SRL_BUS_IDLE;
               pready    <= 1'b0;
               pslverr   <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (bus_setup && !pwrite) begin
         case (paddr)
            SRL_ADDR_CTRL:   prdata <= {24'h00_0000, latch_control[7:2], 2'b00};
            SRL_ADDR_SRC:    prdata <= {24'h00_0000, latch_source_select};
            SRL_ADDR_STATUS: prdata <= {31'h0000_0000, latch_enable_bit & latch_q};
            default:         prdata <= 32'h0000_0000;
         endcase
      end else if (bus_setup) begin
         prdata <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         latch_control       <= SRL_CTRL_RST;
         latch_source_select <= SRL_SRC_RST;
      end else begin
         if (ctrl_wr) begin
            latch_control <= {pwdata[7:2], 2'b00};
         end
         if (src_wr) begin
            latch_source_select <= pwdata[7:0];
         end
      end
   end

   // Pulse bits are write-only strobes: one cycle each
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         software_set_pulse   <= 1'b0;
         software_reset_pulse <= 1'b0;
      end else begin
         software_set_pulse   <= ctrl_wr && pwdata[SRL_CTRL_PSET];
         software_reset_pulse <= ctrl_wr && pwdata[SRL_CTRL_PRST];
      end
   end

   // ==========================================================
   // Periodic pulse generator
   // Free running counter; changing the divider code takes effect at once,
   // so the first period after a change may be short.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt   <= 9'h000;
         div_pulse <= 1'b0;
      end else begin
         div_cnt   <= div_cnt + 9'h001;
         div_pulse <= (div_cnt & period_mask(pulse_divider_select)) == 9'h000;
      end
   end

   // ==========================================================
   // Set and reset gathering
   always_comb begin
      set_in = software_set_pulse
             | (latch_source_select[SRL_SRC_PIN_SET] & latch_input_pin)
             | (latch_source_select[SRL_SRC_CLK_SET] & div_pulse)
             | (latch_source_select[SRL_SRC_C2_SET]  & comp_two)
             | (latch_source_select[SRL_SRC_C1_SET]  & first_comparator);
      rst_in = software_reset_pulse
             | (latch_source_select[SRL_SRC_PIN_RST] & latch_input_pin)
             | (latch_source_select[SRL_SRC_CLK_RST] & div_pulse)
             | (latch_source_select[SRL_SRC_C2_RST]  & comp_two)
             | (latch_source_select[SRL_SRC_C1_RST]  & first_comparator);
   end

   // ==========================================================
   // Latch core
   // Deliberately not reset: its state is unknown until software or a
   // source sets or resets it. Holding is a plain recirculate.
   always_ff @(posedge core_clk) begin
      if (rst_in) begin
         latch_q <= 1'b0;
      end else if (set_in) begin
         latch_q <= 1'b1;
      end
   end

   // ==========================================================
   // Pin outputs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         true_output_pin       <= 1'b0;
         true_output_drive     <= 1'b0;
         inverted_output_pin   <= 1'b0;
         inverted_output_drive <= 1'b0;
      end else begin
         true_output_drive     <= latch_enable_bit & true_output_enable;
         true_output_pin       <= latch_enable_bit & true_output_enable & latch_q;
         inverted_output_drive <= latch_enable_bit & inverted_output_enable;
         inverted_output_pin   <= latch_enable_bit & inverted_output_enable & ~latch_q;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   a_div_pulse_width: assert property (
      div_pulse |=> !div_pulse
   ) else $error("divider pulse wider than one cycle");

   a_div_period_min: assert property (
      disable iff (!rst_b || ctrl_wr)
      (div_pulse && pulse_divider_select == 3'h0) ##1 (!ctrl_wr) [*4]
         |-> $past(!div_pulse) && $past(!div_pulse, 2) && div_pulse
   ) else $error("divider period at code zero is not four");

   a_set_strobe: assert property (
      (ctrl_wr && pwdata[SRL_CTRL_PSET]) |=> software_set_pulse ##1 !software_set_pulse
   ) else $error("software set pulse not one cycle");

   a_reset_strobe: assert property (
      (ctrl_wr && pwdata[SRL_CTRL_PRST]) |=> software_reset_pulse ##1 !software_reset_pulse
   ) else $error("software reset pulse not one cycle");

   a_pulse_read_zero: assert property (
      (pready && !pwrite && paddr == SRL_ADDR_CTRL) |-> prdata[1:0] == 2'b00
   ) else $error("pulse bits read back nonzero");

   a_reset_dominant: assert property (
      (rst_in && set_in) |=> !latch_q
   ) else $error("set overrode reset");

   a_set_takes: assert property (
      (set_in && !rst_in) |=> latch_q ##0 $past(set_in)
   ) else $error("latch did not set");

   a_pins_disabled: assert property (
      !latch_enable_bit |=> !true_output_drive && !inverted_output_drive
         && !true_output_pin && !inverted_output_pin
   ) else $error("pin driven while latch disabled");

   a_true_pin: assert property (
      (latch_enable_bit && true_output_enable) |=> true_output_pin == $past(latch_q)
   ) else $error("true pin does not follow latch");

   a_inv_pin: assert property (
      (latch_enable_bit && inverted_output_enable) |=> inverted_output_pin == !$past(latch_q)
   ) else $error("inverted pin does not follow latch");

   a_pin_source: assert property (
      latch_input_pin |-> (set_in || !latch_source_select[SRL_SRC_PIN_SET])
         && (rst_in || !latch_source_select[SRL_SRC_PIN_RST])
   ) else $error("input pin source ignored");

   a_comp_source: assert property (
      first_comparator |-> (set_in || !latch_source_select[SRL_SRC_C1_SET])
         && (rst_in || !latch_source_select[SRL_SRC_C1_RST])
   ) else $error("first comparator source ignored");

   a_bus_answer: assert property (
      (psel && !penable) |=> pready ##1 !pready
   ) else $error("bus answer not in first access cycle");

   a_bus_error: assert property (
      (psel && !penable && !is_mapped(paddr)) |=> pready && pslverr
   ) else $error("unmapped address not refused");

   // Antecedents on a known latch level only: before software first
   // drives it the latch is unknown and these stay vacuous.
   a_hold_set: assert property (
      (latch_q && !rst_in) |=> latch_q
   ) else $error("latch lost set state");

   a_hold_clear: assert property (
      (!latch_q && !set_in) |=> !latch_q
   ) else $error("latch lost reset state");

   a_comp_two_source: assert property (
      (second_comparator && HAS_COMP_TWO) |-> (set_in || !latch_source_select[SRL_SRC_C2_SET])
         && (rst_in || !latch_source_select[SRL_SRC_C2_RST])
   ) else $error("second comparator source ignored");

   a_pulse_source: assert property (
      div_pulse |-> (set_in || !latch_source_select[SRL_SRC_CLK_SET])
         && (rst_in || !latch_source_select[SRL_SRC_CLK_RST])
   ) else $error("divider pulse source ignored");

   a_quiet_sources: assert property (
      (latch_source_select == 8'h00 && !software_set_pulse && !software_reset_pulse)
         |-> !set_in && !rst_in
   ) else $error("latch input asserted with no source enabled");

   a_set_cause: assert property (
      software_set_pulse |-> $past(ctrl_wr) && $past(pwdata[SRL_CTRL_PSET])
   ) else $error("set strobe without a write");

   a_reset_cause: assert property (
      software_reset_pulse |-> $past(ctrl_wr) && $past(pwdata[SRL_CTRL_PRST])
   ) else $error("reset strobe without a write");

   a_true_drive: assert property (
      (latch_enable_bit && true_output_enable) |=> true_output_drive
   ) else $error("true pin not driven when enabled");

   a_inv_drive: assert property (
      (latch_enable_bit && inverted_output_enable) |=> inverted_output_drive
   ) else $error("inverted pin not driven when enabled");

   c_clock_set:   cover property (latch_source_select[SRL_SRC_CLK_SET] && div_pulse ##1 latch_q);
   c_both_active: cover property (set_in && rst_in);
   c_both_pins:   cover property (true_output_drive && inverted_output_drive);
   c_unmapped:    cover property (pready && pslverr);
   c_clock_reset: cover property (latch_source_select[SRL_SRC_CLK_RST] && div_pulse ##1 !latch_q);
endmodule : srl_latch

// ===== srl_source_model.sv
// Far-side model: external latch input pin and the two comparator outputs.
// Assumes the bench requests new levels just after a rising edge of core_clk.
`timescale 1ns/1ps
module srl_source_model (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic [2:0] want,
   output logic            latch_input_pin,
   output logic            first_comparator,
   output logic            second_comparator
);
   // ==========================================================
   // Levels
   // Registered so every source change lands just after an edge, as a synchronous pin would
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         {second_comparator, first_comparator, latch_input_pin} <= 3'h0;
      end else begin
         {second_comparator, first_comparator, latch_input_pin} <= want;
      end
   end
endmodule : srl_source_model

// ===== srl_latch_bench.sv
// Self-checking bench for the set-reset latch block.
// Assumes a zero-wait APB slave and pins registered one edge after the latch.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module srl_latch_bench;
   import srl_pkg::*;
   logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic        lpin, comp1, comp2, tq, tqd, nq, nqd;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  want;
   int          bad_count, checks_done, n;
   int          set_bit [3] = '{7, 4, 5};
   int          rst_bit [3] = '{3, 0, 1};

   // ==========================================================
   // Instances
   srl_latch u_srl_latch (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .latch_input_pin(lpin), .first_comparator(comp1),
      .second_comparator(comp2), .true_output_pin(tq), .true_output_drive(tqd),
      .inverted_output_pin(nq), .inverted_output_drive(nqd));
   srl_source_model u_srl_source_model (.core_clk(core_clk), .rst_b(rst_b), .want(want),
      .latch_input_pin(lpin), .first_comparator(comp1), .second_comparator(comp2));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // ==========================================================
   // Shared tasks
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out

   // Request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin bad_count++; close_out(); end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task idle(input int c);
      repeat (c) @(posedge core_clk);
   endtask : idle

   // Cycles until the next falling edge of the true output pin
   task fall(output int c);
      logic p;
      c = 0;
      p = tq;
      do begin @(posedge core_clk); c++; if (p === 1'b1 && tq === 1'b0) break; p = tq; end
      while (c < 1100);
      if (c >= 1100) begin bad_count++; close_out(); end
   endtask : fall

   // ==========================================================
   // Scenarios
   task t_reset;
      apb(0, SRL_ADDR_CTRL, 0); `CHK(rd, 32'h0)
      apb(0, SRL_ADDR_SRC, 0); `CHK(rd, 32'h0)
      `CHK({tqd, tq, nqd, nq}, 4'h0)
      apb(1, 8'h10, 32'h0000_00ff); `CHK({err, rd}, 33'h1_0000_0000)
      $display("reset values done");
   endtask : t_reset

   task t_soft;
      // Latch is unknown after reset: clear it before any pin is enabled
      apb(1, SRL_ADDR_CTRL, 32'h01); idle(3);
      apb(1, SRL_ADDR_CTRL, 32'h8e); idle(5); `CHK({tqd, tq, nqd, nq}, 4'b1110)
      apb(0, SRL_ADDR_STATUS, 0); `CHK(rd, 32'h1)
      apb(0, SRL_ADDR_CTRL, 0); `CHK(rd, 32'h8c)
      apb(1, SRL_ADDR_CTRL, 32'h8d); idle(5); `CHK({tqd, tq, nqd, nq}, 4'b1011)
      apb(1, SRL_ADDR_CTRL, 32'h8e); apb(1, SRL_ADDR_CTRL, 32'h8f); idle(5);
      `CHK({tqd, tq, nqd, nq}, 4'b1011)
      apb(1, SRL_ADDR_CTRL, 32'h8e); apb(1, SRL_ADDR_CTRL, 32'h0c); idle(5);
      `CHK({tqd, tq, nqd, nq}, 4'b0000)
      apb(1, SRL_ADDR_CTRL, 32'h88); idle(5); `CHK({tqd, tq, nqd, nq}, 4'b1100)
      apb(1, SRL_ADDR_CTRL, 32'h84); idle(5); `CHK({tqd, tq, nqd, nq}, 4'b0010)
      $display("software pulses done");
   endtask : t_soft

   // Each external source, not enabled as set, then enabled as set and as reset
   task t_sources;
      for (int i = 0; i < 3; i++) begin
         apb(1, SRL_ADDR_SRC, 0); apb(1, SRL_ADDR_CTRL, 32'h8d);
         want <= 3'(1 << i); idle(5); `CHK(tq, 1'b0)
         want <= 3'h0;
         apb(1, SRL_ADDR_SRC, 32'(1 << set_bit[i]));
         want <= 3'(1 << i); idle(5); `CHK(tq, 1'b1)
         want <= 3'h0; idle(3); `CHK(tq, 1'b1)
         apb(1, SRL_ADDR_SRC, 32'(1 << rst_bit[i]));
         want <= 3'(1 << i); idle(5); `CHK(tq, 1'b0)
         want <= 3'h0;
      end
      apb(1, SRL_ADDR_SRC, 32'h88); apb(1, SRL_ADDR_CTRL, 32'h8e); idle(5); `CHK(tq, 1'b1)
      want <= 3'h1; idle(5); `CHK(tq, 1'b0)
      want <= 3'h0;
      $display("external sources done");
   endtask : t_sources

   // Pin holds the latch set; the divider pulse knocks it low once a period
   task t_divider;
      apb(1, SRL_ADDR_SRC, 32'h40); apb(1, SRL_ADDR_CTRL, 32'h8d); idle(8);
      `CHK(tq, 1'b1)
      apb(1, SRL_ADDR_SRC, 32'h84);
      want <= 3'h1;
      for (int c = 0; c < 8; c++) begin
         apb(1, SRL_ADDR_CTRL, 32'h8c | (c << 4));
         fall(n); fall(n); fall(n);
         `CHK(n, 4 << c)
      end
      want <= 3'h0;
      $display("divider periods done");
   endtask : t_divider

   // ==========================================================
   // Main sequence
   initial begin
      rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; want = 3'h0;
      bad_count = 0; checks_done = 0;
      idle(12);
      rst_b <= 1'b1;
      t_reset();
      t_soft();
      t_sources();
      t_divider();
      close_out();
   end
endmodule : srl_latch_bench
